/* File: pkg/vout_monitor_pkg.sv */
package vout_monitor_pkg;
  localparam int CLK_MHZ = 200;
  localparam logic [7:0] CODE_OV_ACTION = 8'h41;
  localparam logic [7:0] CODE_OV_WARN = 8'h42;
  localparam logic [7:0] CODE_UV_WARN = 8'h43;
  localparam int ACTION_MSB = 7;
  localparam int ACTION_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] ACTION_IGNORE = 2'h0;
  localparam logic [1:0] ACTION_BAD = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [7:0] OV_ACTION_RESET = 8'h80;
  // thresholds are kept in quarter-percent units of the commanded level
  localparam logic [15:0] OV_WARN_RESET = 16'h01B8;
  localparam logic [15:0] UV_WARN_RESET = 16'h0168;
  localparam int PCT_SCALE = 400;
  localparam int OVW_MIN_Q = 412;
  localparam int OVW_STEP_Q = 4;
  localparam int OVW_STEPS = 14;
  localparam int UVW_MIN_Q = 336;
  localparam int UVW_STEP_Q = 4;
  localparam int UVW_STEPS = 14;
  localparam int OVF_MIN_Q = 420;
  localparam int OVF_STEP_Q = 10;
  localparam int OVF_STEPS = 15;
  localparam int OVF_OFF_MIN_Q = 440;
  localparam int OVF_OFF_STEP_Q = 40;
  localparam int OVF_OFF_STEPS = 4;
  // gray codes along off, rise, confirm, run, wait
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RISE = 3'h1,
    ST_CONFIRM = 3'h3,
    ST_RUN = 3'h2,
    ST_WAIT = 3'h6,
    ST_LATCHED = 3'h4
  } run_state_t;
endpackage

/* File: rtl/threshold_step_map.sv */
// maps a threshold word onto the nearest supported percentage step in its rounding direction
`timescale 1ns/1ps
module threshold_step_map #(
  parameter int MIN_Q = 412,
  parameter int STEP_Q = 4,
  parameter int N_STEPS = 14,
  parameter bit ROUND_UP = 1'b1
) (
  input wire logic [15:0] word_in,
  input wire logic [15:0] cmd_in,
  input wire logic relative_in,
  output logic [9:0] q_out,
  output logic valid_out
);
  always_comb begin
    logic [9:0] q;
    logic [31:0] lvl;
    logic [31:0] ref_val;
    logic hit;
    q = 10'h000;
    lvl = 32'h0000_0000;
    ref_val = relative_in ? 32'(word_in) : 32'(word_in) * 32'(vout_monitor_pkg::PCT_SCALE);
    hit = 1'b0;
    q_out = 10'h000;
    valid_out = 1'b0;
    for (int i = 0; i < N_STEPS; i++) begin
      // round up scans low to high, round down high to low
      q = ROUND_UP ? 10'(MIN_Q + i * STEP_Q) : 10'(MIN_Q + (N_STEPS - 1 - i) * STEP_Q);
      lvl = relative_in ? 32'(q) : 32'(q) * 32'(cmd_in);
      hit = ROUND_UP ? (lvl >= ref_val) : (lvl <= ref_val);
      if (hit && !valid_out) begin
        q_out = q;
        valid_out = 1'b1;
      end
    end
    // in relative format a word below the lowest step (round up) or above the highest (round down) is unsupported
    if (ROUND_UP && relative_in && word_in < 16'(MIN_Q)) begin
      valid_out = 1'b0;
    end
    if (!ROUND_UP && relative_in && word_in > 16'(MIN_Q + (N_STEPS - 1) * STEP_Q)) begin
      valid_out = 1'b0;
    end
  end
endmodule

/* File: rtl/vout_fault_warn_monitor.sv */
// output-voltage fault response, restart sequencing and warning supervision
`timescale 1ns/1ps
module vout_fault_warn_monitor #(
  parameter int RISE_TIME_US = 1000,
  parameter int STARTUP_TIMEOUT_US = 0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_write_in,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic [15:0] vout_sensed_in,
  input wire logic [15:0] commanded_output_level_in,
  input wire logic output_format_relative_in,
  input wire logic [15:0] ov_fault_threshold_in,
  input wire logic enable_cmd_in,
  input wire logic other_shutdown_fault_in,
  input wire logic clear_faults_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic power_stage_on_out,
  output logic ov_fault_summary_bit_out,
  output logic status_word_vout_out,
  output logic ov_fault_flag_out,
  output logic ov_warning_flag_out,
  output logic uv_warning_flag_out,
  output logic invalid_data_flag_out,
  output logic host_alert_out,
  output logic latched_off_out,
  output logic [2:0] restart_count_out
);
  localparam int RISE_CYC_RAW = RISE_TIME_US * vout_monitor_pkg::CLK_MHZ;
  localparam int RISE_CYC = (RISE_CYC_RAW < 1) ? 1 : RISE_CYC_RAW;
  localparam int TIMEOUT_CYC = STARTUP_TIMEOUT_US * vout_monitor_pkg::CLK_MHZ;
  // confirm window opens after the rise, or after the start-up timeout when that is longer
  localparam int START_CYC = (TIMEOUT_CYC > RISE_CYC) ? TIMEOUT_CYC : RISE_CYC;

  typedef struct packed {
    vout_monitor_pkg::run_state_t run;
    logic [7:0] action;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [2:0] count;
    logic attempt;
    logic [31:0] timer;
    logic ovf_flag;
    logic ovw_flag;
    logic uvw_flag;
    logic summary;
    logic vout_bit;
    logic cml;
    logic alert;
    logic [15:0] rd_data;
    logic rd_valid;
    logic power;
    logic latched;
  } state_t;

  state_t cur;
  state_t nxt;

  logic wr_ovw;
  logic wr_uvw;
  logic [15:0] ovw_word;
  logic [15:0] uvw_word;
  logic [9:0] q_ovw;
  logic [9:0] q_uvw;
  logic [9:0] q_ovf_on;
  logic [9:0] q_ovf_off;
  logic ovw_ok;
  logic uvw_ok;
  logic ovf_on_ok;
  logic ovf_off_ok;

  assign wr_ovw = cmd_write_in && (cmd_code_in == vout_monitor_pkg::CODE_OV_WARN);
  assign wr_uvw = cmd_write_in && (cmd_code_in == vout_monitor_pkg::CODE_UV_WARN);
  // during a write the mapper checks the incoming word instead of the stored one
  assign ovw_word = wr_ovw ? cmd_data_in : cur.ov_warn;
  assign uvw_word = wr_uvw ? cmd_data_in : cur.uv_warn;

  threshold_step_map #(
    .MIN_Q(vout_monitor_pkg::OVW_MIN_Q),
    .STEP_Q(vout_monitor_pkg::OVW_STEP_Q),
    .N_STEPS(vout_monitor_pkg::OVW_STEPS),
    .ROUND_UP(1'b1)
  ) ovw_map (
    .word_in(ovw_word),
    .cmd_in(commanded_output_level_in),
    .relative_in(output_format_relative_in),
    .q_out(q_ovw),
    .valid_out(ovw_ok)
  );

  threshold_step_map #(
    .MIN_Q(vout_monitor_pkg::UVW_MIN_Q),
    .STEP_Q(vout_monitor_pkg::UVW_STEP_Q),
    .N_STEPS(vout_monitor_pkg::UVW_STEPS),
    .ROUND_UP(1'b0)
  ) uvw_map (
    .word_in(uvw_word),
    .cmd_in(commanded_output_level_in),
    .relative_in(output_format_relative_in),
    .q_out(q_uvw),
    .valid_out(uvw_ok)
  );

  threshold_step_map #(
    .MIN_Q(vout_monitor_pkg::OVF_MIN_Q),
    .STEP_Q(vout_monitor_pkg::OVF_STEP_Q),
    .N_STEPS(vout_monitor_pkg::OVF_STEPS),
    .ROUND_UP(1'b1)
  ) ovf_on_map (
    .word_in(ov_fault_threshold_in),
    .cmd_in(commanded_output_level_in),
    .relative_in(output_format_relative_in),
    .q_out(q_ovf_on),
    .valid_out(ovf_on_ok)
  );

  threshold_step_map #(
    .MIN_Q(vout_monitor_pkg::OVF_OFF_MIN_Q),
    .STEP_Q(vout_monitor_pkg::OVF_OFF_STEP_Q),
    .N_STEPS(vout_monitor_pkg::OVF_OFF_STEPS),
    .ROUND_UP(1'b1)
  ) ovf_off_map (
    .word_in(ov_fault_threshold_in),
    .cmd_in(commanded_output_level_in),
    .relative_in(output_format_relative_in),
    .q_out(q_ovf_off),
    .valid_out(ovf_off_ok)
  );

  always_comb begin
    logic [1:0] act;
    logic [2:0] retry;
    logic [2:0] delay;
    logic [31:0] sense_scaled;
    logic [31:0] ovf_lvl;
    logic ovf_trip;
    logic ovw_trip;
    logic uvw_trip;
    logic shut_fault;
    logic [31:0] wait_cyc;
    logic [2:0] bumped;
    logic set_cml;
    nxt = cur;
    act = cur.action[vout_monitor_pkg::ACTION_MSB:vout_monitor_pkg::ACTION_LSB];
    retry = cur.action[vout_monitor_pkg::RETRY_MSB:vout_monitor_pkg::RETRY_LSB];
    delay = cur.action[vout_monitor_pkg::DELAY_MSB:vout_monitor_pkg::DELAY_LSB];
    sense_scaled = 32'(vout_sensed_in) * 32'(vout_monitor_pkg::PCT_SCALE);
    // the fault limit is always relative to the commanded level, even in absolute format
    ovf_lvl = cur.power ? 32'(q_ovf_on) * 32'(commanded_output_level_in)
                        : 32'(q_ovf_off) * 32'(commanded_output_level_in);
    ovf_trip = (cur.power ? ovf_on_ok : ovf_off_ok) && (sense_scaled > ovf_lvl);
    ovw_trip = ovw_ok && (sense_scaled > 32'(q_ovw) * 32'(commanded_output_level_in));
    // undervoltage is only meaningful while the stage regulates
    uvw_trip = uvw_ok && (cur.run == vout_monitor_pkg::ST_RUN)
               && (sense_scaled < 32'(q_uvw) * 32'(commanded_output_level_in));
    shut_fault = other_shutdown_fault_in || (ovf_trip && act != vout_monitor_pkg::ACTION_IGNORE);
    // zero delay still waits one rise time
    wait_cyc = 32'((delay == 3'h0) ? 1 : 32'(delay)) * 32'(RISE_CYC);
    bumped = cur.count + 3'h1;
    set_cml = 1'b0;
    nxt.rd_valid = 1'b0;
    nxt.timer = cur.timer + 32'h0000_0001;

    if (cmd_write_in) begin
      unique case (cmd_code_in)
        vout_monitor_pkg::CODE_OV_ACTION: begin
          if (cmd_data_in[vout_monitor_pkg::ACTION_MSB:vout_monitor_pkg::ACTION_LSB]
              == vout_monitor_pkg::ACTION_BAD) begin
            set_cml = 1'b1;
          end else begin
            nxt.action = cmd_data_in[7:0];
          end
        end
        vout_monitor_pkg::CODE_OV_WARN: begin
          if (ovw_ok) begin
            nxt.ov_warn = cmd_data_in;
          end else begin
            set_cml = 1'b1;
          end
        end
        vout_monitor_pkg::CODE_UV_WARN: begin
          if (uvw_ok) begin
            nxt.uv_warn = cmd_data_in;
          end else begin
            set_cml = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (cmd_read_in) begin
      nxt.rd_valid = 1'b1;
      unique case (cmd_code_in)
        vout_monitor_pkg::CODE_OV_ACTION: nxt.rd_data = {8'h00, cur.action};
        vout_monitor_pkg::CODE_OV_WARN: nxt.rd_data = cur.ov_warn;
        vout_monitor_pkg::CODE_UV_WARN: nxt.rd_data = cur.uv_warn;
        default: nxt.rd_data = 16'h0000;
      endcase
    end

    unique case (cur.run)
      vout_monitor_pkg::ST_OFF: begin
        nxt.count = 3'h0;
        nxt.attempt = 1'b0;
        // ignored fault present at enable blocks start
        if (enable_cmd_in && !ovf_trip && !other_shutdown_fault_in) begin
          nxt.run = vout_monitor_pkg::ST_RISE;
          nxt.timer = 32'h0000_0000;
          nxt.power = 1'b1;
        end
      end
      vout_monitor_pkg::ST_RISE, vout_monitor_pkg::ST_CONFIRM, vout_monitor_pkg::ST_RUN: begin
        if (shut_fault) begin
          nxt.power = 1'b0;
          nxt.timer = 32'h0000_0000;
          nxt.attempt = 1'b0;
          // failed attempt counted against retry field
          if (cur.attempt && retry != vout_monitor_pkg::RETRY_FOREVER) begin
            nxt.count = bumped;
          end
          if (retry == vout_monitor_pkg::RETRY_NONE) begin
            nxt.run = vout_monitor_pkg::ST_LATCHED;
          // latch once attempts are used up
          end else if (cur.attempt && retry != vout_monitor_pkg::RETRY_FOREVER
                       && bumped >= retry) begin
            nxt.run = vout_monitor_pkg::ST_LATCHED;
          end else begin
            nxt.run = vout_monitor_pkg::ST_WAIT;
          end
        end else if (cur.run == vout_monitor_pkg::ST_RISE) begin
          if (cur.timer >= 32'(START_CYC - 1)) begin
            nxt.run = vout_monitor_pkg::ST_CONFIRM;
            nxt.timer = 32'h0000_0000;
          end
        end else if (cur.run == vout_monitor_pkg::ST_CONFIRM) begin
          if (cur.timer >= 32'(RISE_CYC - 1)) begin
            nxt.run = vout_monitor_pkg::ST_RUN;
            nxt.count = 3'h0;
            nxt.attempt = 1'b0;
          end
        end
      end
      vout_monitor_pkg::ST_WAIT: begin
        // one restart-delay period before trying again
        if (cur.timer >= wait_cyc - 32'h0000_0001) begin
          nxt.run = vout_monitor_pkg::ST_RISE;
          nxt.timer = 32'h0000_0000;
          nxt.power = 1'b1;
          nxt.attempt = 1'b1;
        end
      end
      vout_monitor_pkg::ST_LATCHED: begin
        nxt.power = 1'b0;
      end
      default: begin
        nxt.run = vout_monitor_pkg::ST_OFF;
        nxt.power = 1'b0;
      end
    endcase

    // commanded off overrides any sequence and unlatches
    if (!enable_cmd_in) begin
      nxt.run = vout_monitor_pkg::ST_OFF;
      nxt.power = 1'b0;
      nxt.count = 3'h0;
      nxt.attempt = 1'b0;
    end

    // clearing first so that a fresh event in the same cycle wins
    if (clear_faults_in) begin
      nxt.ovf_flag = 1'b0;
      nxt.ovw_flag = 1'b0;
      nxt.uvw_flag = 1'b0;
      nxt.summary = 1'b0;
      nxt.vout_bit = 1'b0;
      nxt.cml = 1'b0;
    end
    if (ovf_trip) begin
      nxt.ovf_flag = 1'b1;
      nxt.summary = 1'b1;
      nxt.vout_bit = 1'b1;
    end
    if (ovw_trip) begin
      nxt.ovw_flag = 1'b1;
      nxt.vout_bit = 1'b1;
    end
    if (uvw_trip) begin
      nxt.uvw_flag = 1'b1;
      nxt.vout_bit = 1'b1;
    end
    if (set_cml) begin
      nxt.cml = 1'b1;
    end
    nxt.alert = nxt.ovf_flag | nxt.ovw_flag | nxt.uvw_flag | nxt.cml;
    // registered copy keeps the latched output glitch free
    nxt.latched = (nxt.run == vout_monitor_pkg::ST_LATCHED);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur <= '{
        run: vout_monitor_pkg::ST_OFF,
        action: vout_monitor_pkg::OV_ACTION_RESET,
        ov_warn: vout_monitor_pkg::OV_WARN_RESET,
        uv_warn: vout_monitor_pkg::UV_WARN_RESET,
        count: 3'h0,
        attempt: 1'b0,
        timer: 32'h0000_0000,
        ovf_flag: 1'b0,
        ovw_flag: 1'b0,
        uvw_flag: 1'b0,
        summary: 1'b0,
        vout_bit: 1'b0,
        cml: 1'b0,
        alert: 1'b0,
        rd_data: 16'h0000,
        rd_valid: 1'b0,
        power: 1'b0,
        latched: 1'b0
      };
    end else begin
      cur <= nxt;
    end
  end

  assign rd_data_out = cur.rd_data;
  assign rd_valid_out = cur.rd_valid;
  assign power_stage_on_out = cur.power;
  assign ov_fault_summary_bit_out = cur.summary;
  assign status_word_vout_out = cur.vout_bit;
  assign ov_fault_flag_out = cur.ovf_flag;
  assign ov_warning_flag_out = cur.ovw_flag;
  assign uv_warning_flag_out = cur.uvw_flag;
  assign invalid_data_flag_out = cur.cml;
  assign host_alert_out = cur.alert;
  assign latched_off_out = cur.latched;
  assign restart_count_out = cur.count;
endmodule

/* File: test/mgmt_host.sv */
// management bus host model driving the command port
`timescale 1ns/1ps
module mgmt_host (
  input wire logic clk_in,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic cmd_write_out,
  output logic cmd_read_out,
  output logic [7:0] cmd_code_out,
  output logic [15:0] cmd_data_out
);
  initial begin
    cmd_write_out = 1'b0;
    cmd_read_out = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 16'h0000;
  end
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk_in);
    cmd_write_out = 1'b1;
    cmd_code_out = code;
    cmd_data_out = data;
    @(negedge clk_in);
    cmd_write_out = 1'b0;
    // released data shows the inverse so a stale value cannot pass
    cmd_data_out = ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = 16'h0000;
    @(negedge clk_in);
    cmd_read_out = 1'b1;
    cmd_code_out = code;
    // the answer stands for one cycle only, so look at every falling edge
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_in);
      cmd_read_out = 1'b0;
      cmd_code_out = ~code;
      ok = (rd_valid_in === 1'b1);
      if (ok) begin
        data = rd_data_in;
      end
    end
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the output-voltage monitor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module testbench;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic wr_s, rd_s, rel_fmt, enable, other_flt, clr_s;
  logic [7:0] code;
  logic [15:0] data, sensed, cmd_lvl, ovf_thr, rd_data;
  logic rd_valid, pwr, sum_b, sw_b, ovf, ovw, uvw, inv, alert, latched;
  logic [2:0] count;
  int failures = 0;
  int cmp_count = 0;
  int n;
  initial forever #2.5 clk_in = ~clk_in;
  initial begin
    sensed = 16'h0FA0;
    cmd_lvl = 16'h0FA0;
    rel_fmt = 1'b1;
    ovf_thr = 16'h01B8;
    enable = 1'b0;
    other_flt = 1'b0;
    clr_s = 1'b0;
  end
  mgmt_host i_host (.clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .cmd_write_out(wr_s), .cmd_read_out(rd_s), .cmd_code_out(code), .cmd_data_out(data));
  vout_fault_warn_monitor #(.RISE_TIME_US(1), .STARTUP_TIMEOUT_US(0)) i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_write_in(wr_s), .cmd_read_in(rd_s),
    .cmd_code_in(code), .cmd_data_in(data), .vout_sensed_in(sensed),
    .commanded_output_level_in(cmd_lvl), .output_format_relative_in(rel_fmt),
    .ov_fault_threshold_in(ovf_thr), .enable_cmd_in(enable), .other_shutdown_fault_in(other_flt),
    .clear_faults_in(clr_s), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .power_stage_on_out(pwr), .ov_fault_summary_bit_out(sum_b), .status_word_vout_out(sw_b),
    .ov_fault_flag_out(ovf), .ov_warning_flag_out(ovw), .uv_warning_flag_out(uvw),
    .invalid_data_flag_out(inv), .host_alert_out(alert), .latched_off_out(latched),
    .restart_count_out(count));
  task test_done;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task rdchk(input logic [7:0] c, input logic [15:0] ex);
    logic [15:0] d;
    logic ok;
    i_host.rd(c, d, ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch rd_valid exp 1 got %0h", ok);
      test_done;
    end
    `CHK("rd_data", ex, d)
  endtask
  task wait_pwr(input logic v, input int lim, output int k);
    k = 0;
    while (pwr !== v) begin
      @(negedge clk_in);
      k++;
      if (k >= lim) begin
        failures++;
        $display("mismatch power_wait exp %0h got %0h", v, pwr);
        test_done;
      end
    end
  endtask
  task settle(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task clr;
    @(negedge clk_in);
    clr_s = 1'b1;
    @(negedge clk_in);
    clr_s = 1'b0;
    @(negedge clk_in);
  endtask
  task off;
    enable = 1'b0;
    clr;
    settle(2);
  endtask
  // start and let the rise and confirm windows pass
  task start_run;
    enable = 1'b1;
    wait_pwr(1'b1, 10, n);
    settle(450);
  endtask
  task trip;
    sensed = 16'h1194;
    wait_pwr(1'b0, 10, n);
    sensed = 16'h0FA0;
  endtask
  task t_reset;
    rdchk(8'h41, 16'h0080);
    rdchk(8'h42, 16'h01B8);
    rdchk(8'h43, 16'h0168);
    rdchk(8'h44, 16'h0000);
  endtask
  task t_invalid;
    i_host.wr(8'h41, 16'h00C0);
    settle(1);
    `CHK("invalid", 1'b1, inv)
    `CHK("alert", 1'b1, alert)
    rdchk(8'h41, 16'h0080);
    clr;
    i_host.wr(8'h42, 16'h0100);
    settle(1);
    `CHK("invalid", 1'b1, inv)
    rdchk(8'h42, 16'h01B8);
    clr;
    `CHK("alert", 1'b0, alert)
  endtask
  task t_warn;
    i_host.wr(8'h42, 16'h019D);
    i_host.wr(8'h43, 16'h0183);
    start_run;
    sensed = 16'h1036;
    settle(3);
    `CHK("ovw", 1'b0, ovw)
    sensed = 16'h104A;
    settle(2);
    `CHK("ovw", 1'b1, ovw)
    `CHK("status_word", 1'b1, sw_b)
    sensed = 16'h0FA0;
    clr;
    sensed = 16'h0F05;
    settle(3);
    `CHK("uvw", 1'b0, uvw)
    sensed = 16'h0EFB;
    settle(2);
    `CHK("uvw", 1'b1, uvw)
    `CHK("alert", 1'b1, alert)
    sensed = 16'h0FA0;
    off;
  endtask
  task t_retry;
    i_host.wr(8'h41, 16'h0053);
    start_run;
    trip;
    `CHK("ovf", 1'b1, ovf)
    `CHK("summary", 1'b1, sum_b)
    `CHK("status_word", 1'b1, sw_b)
    wait_pwr(1'b1, 2000, n);
    `CHK("wait_len", 1'b1, n > 594 && n < 607)
    trip;
    settle(2);
    `CHK("count", 3'h1, count)
    wait_pwr(1'b1, 2000, n);
    settle(450);
    `CHK("count", 3'h0, count)
    trip;
    for (int i = 0; i < 2; i++) begin
      wait_pwr(1'b1, 2000, n);
      trip;
    end
    settle(2);
    `CHK("count", 3'h2, count)
    `CHK("latched", 1'b1, latched)
    settle(700);
    `CHK("power", 1'b0, pwr)
    off;
    `CHK("latched", 1'b0, latched)
  endtask
  task t_modes;
    i_host.wr(8'h41, 16'h0040);
    start_run;
    trip;
    settle(2);
    `CHK("latched", 1'b1, latched)
    settle(700);
    `CHK("power", 1'b0, pwr)
    off;
    i_host.wr(8'h41, 16'h00B8);
    start_run;
    trip;
    for (int i = 0; i < 3; i++) begin
      wait_pwr(1'b1, 2000, n);
      `CHK("wait_len", 1'b1, n > 194 && n < 207)
      trip;
    end
    `CHK("count", 3'h0, count)
    `CHK("latched", 1'b0, latched)
    off;
    `CHK("power", 1'b0, pwr)
  endtask
  task t_ignore;
    i_host.wr(8'h41, 16'h0000);
    sensed = 16'h1194;
    enable = 1'b1;
    settle(20);
    `CHK("power", 1'b0, pwr)
    `CHK("ovf", 1'b1, ovf)
    sensed = 16'h0FA0;
    wait_pwr(1'b1, 10, n);
    sensed = 16'h1194;
    settle(20);
    `CHK("power", 1'b1, pwr)
    sensed = 16'h0FA0;
    off;
  endtask
  // fault limit uses coarse steps while off, fine steps while on
  task t_coarse;
    ovf_thr = 16'h01A4;
    sensed = 16'h10CC;
    settle(3);
    `CHK("ovf", 1'b0, ovf)
    enable = 1'b1;
    wait_pwr(1'b1, 10, n);
    settle(3);
    `CHK("ovf", 1'b1, ovf)
    `CHK("power", 1'b1, pwr)
    sensed = 16'h0FA0;
    ovf_thr = 16'h01B8;
    off;
  endtask
  // a reset while commanded off restores the defaults and drops pending flags
  task t_rst;
    i_host.wr(8'h41, 16'h0012);
    i_host.wr(8'h42, 16'h0300);
    arst_n_in = 1'b0;
    settle(3);
    arst_n_in = 1'b1;
    `CHK("invalid", 1'b0, inv)
    `CHK("alert", 1'b0, alert)
    rdchk(8'h41, 16'h0080);
  endtask
  task t_abs;
    rel_fmt = 1'b0;
    i_host.wr(8'h42, 16'h1036);
    cmd_lvl = 16'h1000;
    settle(2);
    rdchk(8'h42, 16'h1036);
    cmd_lvl = 16'h0FA0;
    rel_fmt = 1'b1;
  endtask
  initial begin
    settle(20);
    arst_n_in = 1'b1;
    t_reset;
    t_invalid;
    t_warn;
    t_retry;
    t_modes;
    t_ignore;
    t_coarse;
    t_abs;
    t_rst;
    test_done;
  end
endmodule

/* File: test/vout_monitor_checker.sv */
// port assertions for the output-voltage fault and warning monitor
`timescale 1ns/1ps
module vout_monitor_checker (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_write_in,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic enable_cmd_in,
  input wire logic rd_valid_out,
  input wire logic power_stage_on_out,
  input wire logic ov_fault_summary_bit_out,
  input wire logic status_word_vout_out,
  input wire logic ov_fault_flag_out,
  input wire logic ov_warning_flag_out,
  input wire logic invalid_data_flag_out,
  input wire logic host_alert_out,
  input wire logic latched_off_out,
  input wire logic [2:0] restart_count_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_rd_answer;
    cmd_read_in |=> rd_valid_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_idle;
    !cmd_read_in |=> !rd_valid_out;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read answer unasked");
  property p_bad_action;
    cmd_write_in && cmd_code_in == 8'h41 && cmd_data_in[7:6] == 2'h3
      |=> invalid_data_flag_out && host_alert_out;
  endproperty
  a_bad_action: assert property (p_bad_action) else $error("bad action not flagged");
  property p_ovf_status;
    $rose(ov_fault_flag_out) |-> ov_fault_summary_bit_out && status_word_vout_out && host_alert_out;
  endproperty
  a_ovf_status: assert property (p_ovf_status) else $error("ov fault bits incomplete");
  property p_ovw_status;
    $rose(ov_warning_flag_out) |-> status_word_vout_out && host_alert_out;
  endproperty
  a_ovw_status: assert property (p_ovw_status) else $error("ov warning bits incomplete");
  property p_latched_dark;
    latched_off_out |-> !power_stage_on_out;
  endproperty
  a_latched_dark: assert property (p_latched_dark) else $error("latched but on");
  property p_latch_holds;
    latched_off_out && enable_cmd_in |=> latched_off_out;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latch left early");
  property p_count_step;
    $changed(restart_count_out) && restart_count_out != 3'h0
      |-> restart_count_out == $past(restart_count_out) + 3'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");
  property p_off_cmd;
    !enable_cmd_in [*2] |-> !power_stage_on_out;
  endproperty
  a_off_cmd: assert property (p_off_cmd) else $error("on while commanded off");
  property p_start_enable;
    $rose(power_stage_on_out) |-> $past(enable_cmd_in);
  endproperty
  a_start_enable: assert property (p_start_enable) else $error("start without enable");
endmodule
bind vout_fault_warn_monitor vout_monitor_checker i_chk (.clk_in, .arst_n_in, .cmd_write_in,
  .cmd_read_in, .cmd_code_in, .cmd_data_in, .enable_cmd_in, .rd_valid_out, .power_stage_on_out,
  .ov_fault_summary_bit_out, .status_word_vout_out, .ov_fault_flag_out, .ov_warning_flag_out,
  .invalid_data_flag_out, .host_alert_out, .latched_off_out, .restart_count_out);
